// *** rtl/rucb_defs.svh ***
// Notes on behaviour
// - Reserved bit positions of every register read back as zero.
// - Writing a one to an operation bit starts its operation; a zero starts nothing.
// - A write to offset 0 with bit 0 set requests reconfiguration in the cycle right after the write.
// - A write to offset 0 with bit 1 set restarts the user watchdog, alone or with reconfig.
// - A write to offset 1 stores bit 0 as the image-override enable of the input register.
// - Bit 1 of a write to offset 1 is stored as the image select, 0 for image 0, 1 for image 1.
// - Busy rises right after a write to offset 1 and later writes there are dropped until it clears.
// - A write to offset 2 starts the selected readbacks and, if any of bits 3:0 is set, raises busy right after the write.
// - Offset 3 reads busy in bit 0 and zero in bits 31 to 1.
// - While busy, every operation write is ignored except the watchdog restart.
// - Offset 4 reads watchdog upper bits in 11:0, watchdog state in 12, machine state in 16:13.
// - Offsets 5 and 6 read source in 3:0 and machine state in 7:4 of previous apps 1 and 2.
// - Offset 7 reads in bits 1:0 the input register value captured by the last input readback, not the stored fields.
`ifndef RUCB_DEFS_SVH
`define RUCB_DEFS_SVH

// Register indexes
`define RUCB_OFS_TRIG    3'h0
`define RUCB_OFS_IMG     3'h1
`define RUCB_OFS_RDBK    3'h2
`define RUCB_OFS_STATUS  3'h3
`define RUCB_OFS_WDOG    3'h4
`define RUCB_OFS_PREV1   3'h5
`define RUCB_OFS_PREV2   3'h6
`define RUCB_OFS_INPUT   3'h7

// Field positions
`define RUCB_BIT_RECONFIG 0
`define RUCB_BIT_WDRST    1
`define RUCB_BIT_OVR      0
`define RUCB_BIT_SEL      1
`define RUCB_RB_BITS      4
`define RUCB_BIT_WRIMG    4
`define RUCB_WDOG_W       17
`define RUCB_PREV_W       8
`define RUCB_IN_W         2

// Reset values
`define RUCB_ZERO32       32'h0000_0000

// Timing
`define RUCB_CLK_NS       20
`define RUCB_PULSE_NS     40
`define RUCB_PULSE_CYC    ((`RUCB_PULSE_NS + `RUCB_CLK_NS - 1) / `RUCB_CLK_NS)

`endif

// *** rtl/rucb_pkg.sv ***
package rucb_pkg;

  typedef enum logic [2:0] {
    OP_RD_WDOG,
    OP_RD_PREV2,
    OP_RD_PREV1,
    OP_RD_INPUT,
    OP_WR_INPUT
  } rucb_op_t;

  typedef enum logic {
    ST_IDLE,
    ST_WAIT
  } rucb_state_t;

  typedef struct packed {
    rucb_state_t state;
    logic        busy;
    logic        ovrEn;
    logic        imgSel;
    logic [4:0]  pend;
    rucb_op_t    op;
    logic        req;
    logic [16:0] wdData;
    logic [7:0]  prev1;
    logic [7:0]  prev2;
    logic [1:0]  inData;
    logic [31:0] rdData;
    logic        rdValid;
  } rucb_csr_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       outN;
  } rucb_pulse_t;

endpackage : rucb_pkg

// *** rtl/rucb_pulse_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module rucb_pulse_gen #(
  parameter int unsigned CYC = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic trig,
  output logic      pulseN
);
  import rucb_pkg::*;

  rucb_pulse_t s;
  rucb_pulse_t next_s;

  // Low pulse of CYC cycles, restarted by a new trigger
  always_comb begin
    next_s = s;
    if (trig) begin
      next_s.cnt = CYC[7:0];
    end else if (s.cnt != 8'h00) begin
      next_s.cnt = s.cnt - 8'h01;
    end
    next_s.outN = (next_s.cnt == 8'h00);
    if (!rst_n) begin
      next_s.cnt  = 8'h00;
      next_s.outN = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign pulseN = s.outN;

endmodule : rucb_pulse_gen
`default_nettype wire

// *** rtl/rucb_op_pick.sv ***
`timescale 1ns/1ps
`default_nettype none
module rucb_op_pick (
  input  wire logic [4:0] pend,
  output logic [2:0]      idx,
  output logic            any
);
  import rucb_pkg::*;

  // Image write first, then readbacks from bit 0 upward
  always_comb begin
    idx = 3'h0;
    any = |pend;
    if (pend[4]) begin
      idx = 3'h4;
    end else begin
      for (int i = 3; i >= 0; i--) begin
        if (pend[i]) begin
          idx = 3'(i);
        end
      end
    end
  end

endmodule : rucb_op_pick
`default_nettype wire

// *** rtl/rucb_csr_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rucb_defs.svh"
module rucb_csr_bank #(
  parameter int unsigned PULSE_CYC = `RUCB_PULSE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [2:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writeData,
  output logic [31:0]      readData,
  output logic             readDataValid,
  output logic             busy,
  output logic             reconfigReqN,
  output logic             wdResetN,
  output rucb_pkg::rucb_op_t hwOp,
  output logic             hwReq,
  output logic [1:0]       hwWrData,
  input  wire logic        hwDone,
  input  wire logic [16:0] hwRdData
);
  import rucb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  rucb_csr_t  s;
  rucb_csr_t  next_s;
  logic       wrTrig;
  logic       wrImg;
  logic       wrRdbk;
  logic       reconfigGo;
  logic       wdogGo;
  logic [4:0] newPend;
  logic [4:0] doneMask;
  logic [2:0] selIdx;
  logic       selAny;

  assign wrTrig = write && (address == `RUCB_OFS_TRIG);
  assign wrImg  = write && (address == `RUCB_OFS_IMG);
  assign wrRdbk = write && (address == `RUCB_OFS_RDBK);

  // Launched in the write cycle itself
  assign reconfigGo = wrTrig && writeData[`RUCB_BIT_RECONFIG] && !s.busy;
  assign wdogGo     = wrTrig && writeData[`RUCB_BIT_WDRST];

  ////////////////////////////////////////////////////////////////////////////
  // Trigger pulses and operation selection

  rucb_pulse_gen #(
    .CYC (PULSE_CYC)
  ) u_reconfig (
    .clk    (clk),
    .rst_n  (rst_n),
    .trig   (reconfigGo),
    .pulseN (reconfigReqN)
  );

  rucb_pulse_gen #(
    .CYC (PULSE_CYC)
  ) u_wdog (
    .clk    (clk),
    .rst_n  (rst_n),
    .trig   (wdogGo),
    .pulseN (wdResetN)
  );

  rucb_op_pick u_pick (
    .pend (s.pend),
    .idx  (selIdx),
    .any  (selAny)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s   = s;
    newPend  = 5'h00;
    doneMask = 5'h00;

    // Input register write
    if (wrImg && !s.busy) begin
      next_s.ovrEn  = writeData[`RUCB_BIT_OVR];
      next_s.imgSel = writeData[`RUCB_BIT_SEL];
      newPend[`RUCB_BIT_WRIMG] = 1'b1;
    end

    // Readback triggers, zero bits start nothing
    if (wrRdbk && !s.busy) begin
      newPend[3:0] = writeData[`RUCB_RB_BITS-1:0];
    end

    // Hardware handshake, one operation at a time
    case (s.state)
      ST_IDLE: begin
        if (selAny) begin
          next_s.op    = rucb_op_t'(selIdx);
          next_s.req   = 1'b1;
          next_s.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (hwDone) begin
          next_s.req   = 1'b0;
          next_s.state = ST_IDLE;
          doneMask     = 5'h01 << s.op;
          case (s.op)
            OP_RD_WDOG:  next_s.wdData = hwRdData;
            OP_RD_PREV2: next_s.prev2  = hwRdData[`RUCB_PREV_W-1:0];
            OP_RD_PREV1: next_s.prev1  = hwRdData[`RUCB_PREV_W-1:0];
            OP_RD_INPUT: next_s.inData = hwRdData[`RUCB_IN_W-1:0];
            default: begin
            end
          endcase
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase

    // New requests win over completion clears
    next_s.pend = (s.pend & ~doneMask) | newPend;
    next_s.busy = (|next_s.pend) || (next_s.state != ST_IDLE);

    // Read port, one cycle latency
    next_s.rdValid = read;
    next_s.rdData  = `RUCB_ZERO32;
    if (read) begin
      if (address == `RUCB_OFS_STATUS) begin
        next_s.rdData = {31'h0000_0000, s.busy};
      end else if (address == `RUCB_OFS_WDOG) begin
        next_s.rdData = {15'h0000, s.wdData};
      end else if (address == `RUCB_OFS_PREV1) begin
        next_s.rdData = {24'h00_0000, s.prev1};
      end else if (address == `RUCB_OFS_PREV2) begin
        next_s.rdData = {24'h00_0000, s.prev2};
      end else if (address == `RUCB_OFS_INPUT) begin
        next_s.rdData = {30'h0000_0000, s.inData};
      end else begin
        next_s.rdData = `RUCB_ZERO32;
      end
    end

    if (!rst_n) begin
      next_s.state   = ST_IDLE;
      next_s.busy    = 1'b0;
      next_s.ovrEn   = 1'b0;
      next_s.imgSel  = 1'b0;
      next_s.pend    = 5'h00;
      next_s.op      = OP_RD_WDOG;
      next_s.req     = 1'b0;
      next_s.wdData  = 17'h0_0000;
      next_s.prev1   = 8'h00;
      next_s.prev2   = 8'h00;
      next_s.inData  = 2'h0;
      next_s.rdData  = `RUCB_ZERO32;
      next_s.rdValid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign readData      = s.rdData;
  assign readDataValid = s.rdValid;
  assign busy          = s.busy;
  assign hwOp          = s.op;
  assign hwReq         = s.req;
  assign hwWrData      = {s.imgSel, s.ovrEn};

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_img_write_busy: assert property (
    wrImg && !busy |=> busy && hwWrData == $past(writeData[1:0])
  ) else $error("Image write did not raise busy or store fields");

  a_img_write_drop: assert property (
    wrImg && busy |=> $stable(hwWrData)
  ) else $error("Image write while busy changed input register");

  a_rdbk_busy: assert property (
    wrRdbk && !busy && (|writeData[3:0]) |=> busy
  ) else $error("Readback write did not raise busy");

  a_rdbk_zero: assert property (
    wrRdbk && !busy && writeData[3:0] == 4'h0 && !busy && !wrImg |=> !busy
  ) else $error("Zero readback write started an operation");

  a_reconfig_fire: assert property (
    wrTrig && writeData[0] && !busy |=> !reconfigReqN
  ) else $error("Reconfig request not launched");

  a_reconfig_block: assert property (
    wrTrig && busy && reconfigReqN |=> reconfigReqN
  ) else $error("Reconfig launched while busy");

  a_wdog_fire: assert property (
    wrTrig && writeData[1] |=> !wdResetN
  ) else $error("Watchdog restart not launched");

  a_status_read: assert property (
    read && address == 3'h3 |=> readDataValid && readData == {31'h0000_0000, $past(busy)}
  ) else $error("Status word wrong");

  a_wo_read_zero: assert property (
    read && address < 3'h3 |=> readData == 32'h0000_0000
  ) else $error("Write-only offset read nonzero");

  a_reserved_zero: assert property (
    readDataValid |-> readData[31:17] == 15'h0000
  ) else $error("Reserved bits read nonzero");

  a_reset_clear: assert property (
    disable iff (1'b0) !rst_n |=> !busy && !hwReq && hwWrData == 2'h0
  ) else $error("Reset did not clear state");

  a_rdbk_drop: assert property (
    wrRdbk && busy |=> (s.pend[3:0] & ~$past(s.pend[3:0])) == 4'h0
  ) else $error("Readback write while busy started an operation");

  a_wdog_busy: assert property (
    wrTrig && writeData[1] && busy |=> !wdResetN
  ) else $error("Watchdog restart dropped while busy");

  a_reconfig_width: assert property (
    $rose(reconfigReqN) |-> $past(reconfigGo, PULSE_CYC + 1)
  ) else $error("Reconfig request pulse has wrong width");

  a_wdog_width: assert property (
    $rose(wdResetN) |-> $past(wdogGo, PULSE_CYC + 1)
  ) else $error("Watchdog restart pulse has wrong width");

  a_img_first: assert property (
    s.state == ST_IDLE && s.pend[4] |=> hwReq && hwOp == OP_WR_INPUT
  ) else $error("Image write not issued first");

  a_op_pending: assert property (
    $rose(hwReq) |-> ($past(s.pend) & (5'h01 << hwOp)) != 5'h00
  ) else $error("Issued operation was not pending");

  a_op_order: assert property (
    $rose(hwReq) && hwOp != OP_WR_INPUT |->
      !$past(s.pend[4]) && ($past(s.pend) & ((5'h01 << hwOp) - 5'h01)) == 5'h00
  ) else $error("Readbacks issued out of order");

  a_req_hold: assert property (
    hwReq && !hwDone |=> hwReq && $stable(hwOp)
  ) else $error("Operation request dropped before done");

  a_req_drop: assert property (
    hwReq && hwDone |=> !hwReq
  ) else $error("Operation request held after done");

  a_wdog_capture: assert property (
    hwReq && hwDone && hwOp == OP_RD_WDOG |=> s.wdData == $past(hwRdData)
  ) else $error("Watchdog readback not captured");

  a_prev1_capture: assert property (
    hwReq && hwDone && hwOp == OP_RD_PREV1 |=> s.prev1 == $past(hwRdData[7:0])
  ) else $error("Previous state 1 readback not captured");

  a_prev2_capture: assert property (
    hwReq && hwDone && hwOp == OP_RD_PREV2 |=> s.prev2 == $past(hwRdData[7:0])
  ) else $error("Previous state 2 readback not captured");

  a_input_capture: assert property (
    hwReq && hwDone && hwOp == OP_RD_INPUT |=> s.inData == $past(hwRdData[1:0])
  ) else $error("Input register readback not captured");

  a_busy_clear: assert property (
    hwReq && hwDone && s.pend == (5'h01 << hwOp) && !wrImg && !wrRdbk |=> !busy
  ) else $error("Busy held after last operation");

  a_read_quiet: assert property (
    !read |=> !readDataValid && readData == 32'h0000_0000
  ) else $error("Read data shown without a read");

  a_low_reserved: assert property (
    readDataValid && $past(address) != 3'h4 |-> readData[31:8] == 24'h00_0000
  ) else $error("Reserved bits above low byte read nonzero");

  a_input_reserved: assert property (
    readDataValid && $past(address) == 3'h7 |-> readData[31:2] == 30'h0000_0000
  ) else $error("Input register word reserved bits nonzero");

  a_reset_pulses: assert property (
    disable iff (1'b0) !rst_n |=> reconfigReqN && wdResetN && !readDataValid
  ) else $error("Reset did not end pulses or read data");

endmodule : rucb_csr_bank
`default_nettype wire

// *** verif/rucb_hw_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rucb_hw_model (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               slow,
  input  wire logic               hwReq,
  input  wire rucb_pkg::rucb_op_t hwOp,
  input  wire logic [1:0]         hwWrData,
  output logic                    hwDone,
  output logic [16:0]             hwRdData
);
  import rucb_pkg::*;
  logic [3:0]  cnt;
  logic        held;
  logic [1:0]  img;
  logic [16:0] junk;
  // Answers each request once, at once or after a delay
  always_ff @(posedge clk) begin
    junk   <= ~junk ^ 17'h0_1357;
    hwDone <= 1'b0;
    if (!rst_n) begin
      cnt  <= 4'h0;
      held <= 1'b0;
      img  <= 2'h0;
      junk <= 17'h0_0F0F;
    end else if (!hwReq) begin
      held <= 1'b0;
      cnt  <= 4'h0;
    end else if (!held) begin
      cnt <= cnt + 4'h1;
      if (cnt >= (slow ? 4'h6 : 4'h0)) begin
        hwDone <= 1'b1;
        held   <= 1'b1;
        if (hwOp == OP_WR_INPUT) img <= hwWrData;
      end
    end
  end
  // Data only while done, a moving pattern otherwise
  always_comb begin
    hwRdData = junk;
    if (hwDone) begin
      case (hwOp)
        OP_RD_WDOG:  hwRdData = 17'h1_5A3C;
        OP_RD_PREV2: hwRdData = 17'h1_FFA6;
        OP_RD_PREV1: hwRdData = 17'h0_3C5B;
        OP_RD_INPUT: hwRdData = {15'h5555, img};
        default:     hwRdData = junk;
      endcase
    end
  end
endmodule : rucb_hw_model
`default_nettype wire

// *** verif/rucb_csr_bank_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module rucb_csr_bank_test;
  import rucb_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [2:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writeData;
  logic [31:0] readData;
  logic        readDataValid;
  logic        busy;
  logic        reconfigReqN;
  logic        wdResetN;
  rucb_op_t    hwOp;
  logic        hwReq;
  logic [1:0]  hwWrData;
  logic        hwDone;
  logic [16:0] hwRdData;
  logic        slowHw;
  logic [1:0]  img;
  logic [31:0] rdQ[$];
  int          pendR;
  int          pendW;
  int          lowR;
  int          lowW;
  int          failures;
  int          n_compared;
  int          cycles;
  rucb_csr_bank #(.PULSE_CYC(2)) u_rucb_csr_bank (.clk, .rst_n, .address, .read, .write,
    .writeData, .readData, .readDataValid, .busy, .reconfigReqN, .wdResetN, .hwOp,
    .hwReq, .hwWrData, .hwDone, .hwRdData);
  rucb_hw_model u_rucb_hw_model (.clk, .rst_n, .slow(slowHw), .hwReq, .hwOp,
    .hwWrData, .hwDone, .hwRdData);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", w, e, g);
      failures++;
    end
  endtask : chk
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    address   <= a;
    writeData <= d;
    write     <= 1'b1;
    @(posedge clk);
    write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    @(posedge clk);
    address <= a;
    read    <= 1'b1;
    rdQ.push_back(e);
    @(posedge clk);
    read <= 1'b0;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic waitIdle;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (busy !== 1'b0 && n < 300);
    chk("busy", 32'h0, {31'h0, busy});
  endtask : waitIdle
  ////////////////////////////////////////
  // Watches results and takes the oldest note
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      give_verdict();
    end else if (rst_n === 1'b1) begin
      if (readDataValid === 1'b1) begin
        if (rdQ.size() == 0) chk("read count", 32'h0, 32'h1);
        else chk("readData", rdQ.pop_front(), readData);
      end
      if (reconfigReqN !== 1'b1) lowR++;
      else if (lowR > 0) begin
        chk("reconfig pulse", 32'h1, {31'h0, pendR > 0});
        chk("reconfig width", 32'h2, lowR);
        pendR--;
        lowR = 0;
      end
      if (wdResetN !== 1'b1) lowW++;
      else if (lowW > 0) begin
        chk("restart pulse", 32'h1, {31'h0, pendW > 0});
        chk("restart width", 32'h2, lowW);
        pendW--;
        lowW = 0;
      end
    end
  end
  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    address = 3'h0;
    read = 1'b0;
    write = 1'b0;
    writeData = 32'h0;
    slowHw = 1'b0;
    {failures, n_compared, cycles, pendR, pendW, lowR, lowW} = '0;
    img = 2'($urandom(32'h54e54d5d));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(3'(a), 32'h0);
    $display("test reset values done");
    pendR++;
    wr(3'h0, ($urandom & 32'hFFFF_FFFC) | 32'h1);
    idle(4);
    pendW++;
    wr(3'h0, 32'h2);
    idle(4);
    pendR++;
    pendW++;
    wr(3'h0, 32'h3);
    idle(4);
    wr(3'h0, 32'h0);
    idle(4);
    $display("test triggers done");
    slowHw <= 1'b1;
    wr(3'h1, ($urandom & 32'hFFFF_FFFC) | {30'h0, img});
    rd(3'h3, 32'h1);
    wr(3'h1, {30'h0, ~img});
    wr(3'h2, 32'h1);
    waitIdle();
    chk("hwWrData", {30'h0, img}, {30'h0, hwWrData});
    rd(3'h4, 32'h0);
    wr(3'h2, 32'h8);
    rd(3'h3, 32'h1);
    waitIdle();
    rd(3'h7, {30'h0, img});
    $display("test image select done");
    slowHw <= 1'b0;
    wr(3'h2, 32'hFFFF_FFF7);
    pendW++;
    wr(3'h0, 32'h3);
    wr(3'h1, {30'h0, ~img});
    waitIdle();
    chk("hwWrData", {30'h0, img}, {30'h0, hwWrData});
    rd(3'h4, 32'h0001_5A3C);
    rd(3'h5, 32'h0000_005B);
    rd(3'h6, 32'h0000_00A6);
    rd(3'h0, 32'h0);
    $display("test readbacks done");
    for (int a = 3; a < 8; a++) wr(3'(a), $urandom);
    rd(3'h3, 32'h0);
    rd(3'h4, 32'h0001_5A3C);
    rd(3'h7, {30'h0, img});
    $display("test read-only writes done");
    wr(3'h2, 32'hF);
    idle(2);
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    rd(3'h3, 32'h0);
    chk("hwWrData", 32'h0, {30'h0, hwWrData});
    idle(20);
    rd(3'h3, 32'h0);
    idle(5);
    chk("reads left", 32'h0, rdQ.size());
    chk("pulses left", 32'h0, pendR + pendW);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule : rucb_csr_bank_test
`default_nettype wire
